// *** hdl/core_event_pkg.sv ***
/*
  package for the core event stage: event indices, counts, modes, carriers.
  assumes one core clock domain and synchronous inputs.
*/
package core_event_pkg;
  localparam int unsigned NUM_EVT = 16;
  localparam int unsigned LVL_W = 4;
  localparam int unsigned NUM_GEN = 9;
  localparam int unsigned ADDR_W = 32;
  localparam logic [LVL_W-1:0] EVT_EMU = 4'h0;
  localparam logic [LVL_W-1:0] EVT_RST = 4'h1;
  localparam logic [LVL_W-1:0] EVT_NMI = 4'h2;
  localparam logic [LVL_W-1:0] EVT_EXC = 4'h3;
  localparam logic [LVL_W-1:0] EVT_RSV = 4'h4;
  localparam logic [LVL_W-1:0] EVT_HWE = 4'h5;
  localparam logic [LVL_W-1:0] EVT_TMR = 4'h6;
  localparam logic [LVL_W-1:0] EVT_GEN_FIRST = 4'h7;
  localparam logic [LVL_W-1:0] EVT_SW_FIRST = 4'he;
  localparam logic [NUM_EVT-1:0] ALWAYS_UNMASKED = 16'h000f;
  localparam logic [NUM_EVT-1:0] UNMASK_RESET = 16'h001f;
  localparam logic [NUM_EVT-1:0] ZERO_EVT = 16'h0000;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 32'h0000_0000;
  localparam logic [1:0] SYNC_STAGES = 2'h2;

  typedef enum logic [1:0] {
    MODE_USER,
    MODE_SUPER,
    MODE_EMU
  } core_mode_e;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SAVE,
    ST_ENTER
  } seq_state_e;

  typedef struct packed {
    logic [NUM_EVT-1:0] latch;
    logic [NUM_EVT-1:0] unmask;
    logic [NUM_EVT-1:0] nest;
  } event_regs_s;

  typedef struct packed {
    logic valid;
    logic [LVL_W-1:0] level;
    logic [ADDR_W-1:0] ret_addr;
  } event_take_s;
endpackage

// *** hdl/edge_latch.sv ***
/*
  rising edge detector for one general level: two-flop sample then edge.
  assumes the input is synchronous to the core clock.
*/
`timescale 1ns/100ps
module edge_latch (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_level,
  output logic o_rise
);
  logic [1:0] hist_q;
  logic [1:0] hist_d;
  logic rise_q;
  logic rise_d;

  always_comb begin
    hist_d = {hist_q[0], i_level};
    rise_d = hist_q[0] & ~hist_q[1];
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_q <= 2'h0;
      rise_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      rise_q <= rise_d;
    end
  end

  assign o_rise = rise_q;
endmodule

// *** hdl/core_event_stage.sv ***
/*
  core event stage: latches, unmasks, prioritises and nests sixteen events,
  keeps per-level return addresses and steps the sequencer into handlers.
  assumes the routing stage drives the nine general levels synchronously.
*/
// Summary of operation
// - accepted events may preempt a running handler; nesting bits track all active.
// - among competing unmasked events the lowest index, highest priority, wins.
// - five classes: emulation, reset, nonmaskable, exception, general interrupt.
// - emulation event switches the core to emulation mode under test port control.
// - reset event raises a whole-processor reset request.
// - nonmaskable event raised by watchdog or by the nonmaskable pin.
// - exceptions taken synchronously, before the faulting instruction completes.
// - general levels come from pins, timers, peripherals or a software raise.
// - each level keeps its return address; return-from-event resumes there.
// - state is pushed to the supervisor stack before handler entry.
// - peripheral requests arrive through the routing stage onto general levels.
// - nine general levels, 7 to 15, beside the dedicated events.
// - core runs in supervisor or emulation mode; user mode is declared but never entered.
// - a general latch bit sets on a rising edge, detected in two cycles.
// - rising edge to nesting bit takes at least three cycles.
// - set unmask bit allows service; cleared bit blocks but keeps the latch.
`timescale 1ns/100ps
module core_event_stage (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_emu_req,
  input wire logic i_reset_req,
  input wire logic i_nmi_pin,
  input wire logic i_watchdog_nmi,
  input wire logic i_exc_misalign,
  input wire logic i_exc_undef,
  input wire logic i_hw_error,
  input wire logic i_core_timer,
  input wire logic [core_event_pkg::NUM_GEN-1:0] i_general_event_levels,
  input wire logic i_soft_raise,
  input wire logic [core_event_pkg::LVL_W-1:0] i_soft_raise_level,
  input wire logic [core_event_pkg::ADDR_W-1:0] i_pc,
  input wire logic i_return,
  input wire logic i_unmask_we,
  input wire logic [core_event_pkg::NUM_EVT-1:0] i_unmask_wdata,
  input wire logic i_latch_clr_we,
  input wire logic [core_event_pkg::NUM_EVT-1:0] i_latch_clr_bits,
  input wire logic i_save_done,
  input wire logic i_emu_exit,
  output logic [core_event_pkg::NUM_EVT-1:0] o_event_latch_bits,
  output logic [core_event_pkg::NUM_EVT-1:0] o_event_unmask_bits,
  output logic [core_event_pkg::NUM_EVT-1:0] o_active_nesting_bits,
  output logic o_take_valid,
  output logic [core_event_pkg::LVL_W-1:0] o_take_level,
  output logic [core_event_pkg::ADDR_W-1:0] o_resume_addr,
  output logic o_resume_valid,
  output logic o_save_req,
  output logic o_kill_insn,
  output logic o_sys_reset,
  output logic [1:0] o_core_mode
);
  localparam int unsigned N = core_event_pkg::NUM_EVT;

  core_event_pkg::event_regs_s regs_q;
  core_event_pkg::event_regs_s regs_d;
  core_event_pkg::seq_state_e st_q;
  core_event_pkg::seq_state_e st_d;
  core_event_pkg::core_mode_e mode_q;
  core_event_pkg::core_mode_e mode_d;
  core_event_pkg::event_take_s take_q;
  core_event_pkg::event_take_s take_d;
  logic [core_event_pkg::ADDR_W-1:0] ret_q [N];
  logic [core_event_pkg::ADDR_W-1:0] ret_d [N];
  logic [core_event_pkg::LVL_W-1:0] pend_lvl_q;
  logic [core_event_pkg::LVL_W-1:0] pend_lvl_d;
  logic [core_event_pkg::ADDR_W-1:0] resume_q;
  logic [core_event_pkg::ADDR_W-1:0] resume_d;
  logic resume_v_q;
  logic resume_v_d;
  logic save_q;
  logic save_d;
  logic kill_q;
  logic kill_d;
  logic sysrst_q;
  logic sysrst_d;
  logic [N-1:0] raw_set;
  logic [N-1:0] gen_rise;
  logic [N-1:0] eligible;
  logic [N-1:0] nest_ceiling;
  logic found;
  logic [core_event_pkg::LVL_W-1:0] win;
  logic ret_found;
  logic [core_event_pkg::LVL_W-1:0] ret_lvl;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lvl
      if (g >= int'(core_event_pkg::EVT_GEN_FIRST)) begin : g_gen
        edge_latch u_edge (
          .i_clock(i_clock),
          .i_rst_n(i_rst_n),
          .i_level(i_general_event_levels[g - int'(core_event_pkg::EVT_GEN_FIRST)]),
          .o_rise(gen_rise[g])
        );
      end else begin : g_ded
        assign gen_rise[g] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    raw_set = gen_rise;
    raw_set[core_event_pkg::EVT_EMU] = i_emu_req;
    raw_set[core_event_pkg::EVT_RST] = i_reset_req;
    raw_set[core_event_pkg::EVT_NMI] = i_nmi_pin | i_watchdog_nmi;
    raw_set[core_event_pkg::EVT_EXC] = i_exc_misalign | i_exc_undef;
    raw_set[core_event_pkg::EVT_HWE] = i_hw_error;
    raw_set[core_event_pkg::EVT_TMR] = i_core_timer;
    if (i_soft_raise && i_soft_raise_level >= core_event_pkg::EVT_GEN_FIRST) begin
      raw_set[i_soft_raise_level] = 1'b1;
    end
    raw_set[core_event_pkg::EVT_RSV] = 1'b0;
  end

  always_comb begin
    // only levels above the highest active one may preempt
    nest_ceiling = '0;
    found = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (!found) begin
        if (regs_q.nest[i]) begin
          found = 1'b1;
        end else begin
          nest_ceiling[i] = 1'b1;
        end
      end
    end
    eligible = regs_q.latch & regs_q.unmask & nest_ceiling;
    win = '0;
    found = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        win = core_event_pkg::LVL_W'(i);
        found = 1'b1;
      end
    end
    ret_lvl = '0;
    ret_found = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (regs_q.nest[i]) begin
        ret_lvl = core_event_pkg::LVL_W'(i);
        ret_found = 1'b1;
      end
    end
  end

  always_comb begin
    regs_d = regs_q;
    st_d = st_q;
    mode_d = mode_q;
    take_d = take_q;
    take_d.valid = 1'b0;
    ret_d = ret_q;
    pend_lvl_d = pend_lvl_q;
    resume_d = resume_q;
    resume_v_d = 1'b0;
    save_d = 1'b0;
    kill_d = 1'b0;
    sysrst_d = 1'b0;
    if (i_unmask_we) begin
      regs_d.unmask = i_unmask_wdata | core_event_pkg::ALWAYS_UNMASKED;
    end
    if (i_latch_clr_we) begin
      regs_d.latch = regs_d.latch & ~(i_latch_clr_bits & ~regs_q.unmask);
    end
    if (i_return && ret_found && st_q == core_event_pkg::ST_RUN) begin
      regs_d.nest[ret_lvl] = 1'b0;
      resume_d = ret_q[ret_lvl];
      resume_v_d = 1'b1;
      if (ret_lvl == core_event_pkg::EVT_EMU) begin
        mode_d = core_event_pkg::MODE_SUPER;
      end
    end
    if (i_emu_exit && mode_q == core_event_pkg::MODE_EMU) begin
      mode_d = core_event_pkg::MODE_SUPER;
    end
    case (st_q)
      core_event_pkg::ST_RUN: begin
        if (found && !i_return) begin
          pend_lvl_d = win;
          ret_d[win] = i_pc;
          save_d = 1'b1;
          kill_d = (win == core_event_pkg::EVT_EXC);
          st_d = core_event_pkg::ST_SAVE;
        end
      end
      core_event_pkg::ST_SAVE: begin
        save_d = ~i_save_done;
        if (i_save_done) begin
          st_d = core_event_pkg::ST_ENTER;
        end
      end
      core_event_pkg::ST_ENTER: begin
        regs_d.latch[pend_lvl_q] = 1'b0;
        regs_d.nest[pend_lvl_q] = 1'b1;
        take_d.valid = 1'b1;
        take_d.level = pend_lvl_q;
        take_d.ret_addr = ret_q[pend_lvl_q];
        sysrst_d = (pend_lvl_q == core_event_pkg::EVT_RST);
        mode_d = (pend_lvl_q == core_event_pkg::EVT_EMU) ?
          core_event_pkg::MODE_EMU : core_event_pkg::MODE_SUPER;
        st_d = core_event_pkg::ST_RUN;
      end
      default: begin
        st_d = core_event_pkg::ST_RUN;
      end
    endcase
    // new events win over any clear in the same cycle
    regs_d.latch = regs_d.latch | raw_set;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      regs_q <= '{latch: core_event_pkg::ZERO_EVT, unmask: core_event_pkg::UNMASK_RESET,
                  nest: core_event_pkg::ZERO_EVT};
      st_q <= core_event_pkg::ST_RUN;
      mode_q <= core_event_pkg::MODE_SUPER;
      take_q <= '0;
      for (int i = 0; i < N; i++) begin
        ret_q[i] <= core_event_pkg::ZERO_ADDR;
      end
      pend_lvl_q <= '0;
      resume_q <= core_event_pkg::ZERO_ADDR;
      resume_v_q <= 1'b0;
      save_q <= 1'b0;
      kill_q <= 1'b0;
      sysrst_q <= 1'b0;
    end else begin
      regs_q <= regs_d;
      st_q <= st_d;
      mode_q <= mode_d;
      take_q <= take_d;
      ret_q <= ret_d;
      pend_lvl_q <= pend_lvl_d;
      resume_q <= resume_d;
      resume_v_q <= resume_v_d;
      save_q <= save_d;
      kill_q <= kill_d;
      sysrst_q <= sysrst_d;
    end
  end

  assign o_event_latch_bits = regs_q.latch;
  assign o_event_unmask_bits = regs_q.unmask;
  assign o_active_nesting_bits = regs_q.nest;
  assign o_take_valid = take_q.valid;
  assign o_take_level = take_q.level;
  assign o_resume_addr = resume_q;
  assign o_resume_valid = resume_v_q;
  assign o_save_req = save_q;
  assign o_kill_insn = kill_q;
  assign o_sys_reset = sysrst_q;
  assign o_core_mode = mode_q;
endmodule

// *** dv/routing_stage_model.sv ***
/*
  routing stage model: forwards peripheral requests onto general levels.
  assumes requests are synchronous to the core clock.
*/
`timescale 1ns/100ps
module routing_stage_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [6:0] i_periph_req,
  output logic [8:0] o_levels
);
  // peripheral k drives level 7+k; levels 14 and 15 stay free for software
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) o_levels <= 9'h000;
    else o_levels <= {2'h0, i_periph_req};
  end
endmodule

// *** dv/core_event_stage_asserts.sv ***
/*
  checker for the core event stage ports.
  assumes bind onto the design top module.
*/
`timescale 1ns/100ps
module core_event_stage_asserts (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [8:0] i_general_event_levels,
  input wire logic i_save_done,
  input wire logic i_return,
  input wire logic i_unmask_we,
  input wire logic [15:0] i_unmask_wdata,
  input wire logic [15:0] o_event_latch_bits,
  input wire logic [15:0] o_event_unmask_bits,
  input wire logic [15:0] o_active_nesting_bits,
  input wire logic o_take_valid,
  input wire logic [3:0] o_take_level,
  input wire logic o_save_req,
  input wire logic o_kill_insn,
  input wire logic o_resume_valid
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_latch; $rose(i_general_event_levels[0]) |-> ##[1:3] o_event_latch_bits[7];
  endproperty
  property p_lat; $rose(i_general_event_levels[0]) && !o_event_latch_bits[7]
    && !o_active_nesting_bits[7] |-> !o_active_nesting_bits[7] [*3]; endproperty
  property p_hold; o_save_req && !i_save_done |=> o_save_req; endproperty
  property p_enter; o_save_req && i_save_done |=> !o_save_req ##1 o_take_valid; endproperty
  property p_top; o_take_valid |-> o_active_nesting_bits[o_take_level] &&
    (o_active_nesting_bits & ((16'h0001 << o_take_level) - 16'h0001)) == 16'h0000;
  endproperty
  property p_kill; o_kill_insn |-> o_save_req && o_event_latch_bits[3]; endproperty
  property p_ret; i_return && o_active_nesting_bits != 16'h0000 |=> o_resume_valid;
  endproperty
  property p_mask; i_unmask_we |=> o_event_unmask_bits == ($past(i_unmask_wdata) | 16'h000f);
  endproperty
  a_latch: assert property (p_latch) else $error("edge not latched");
  a_lat: assert property (p_lat) else $error("edge to nest too fast");
  a_hold: assert property (p_hold) else $error("save request dropped");
  a_enter: assert property (p_enter) else $error("no entry after save");
  a_top: assert property (p_top) else $error("take order wrong");
  a_kill: assert property (p_kill) else $error("kill without exception");
  a_ret: assert property (p_ret) else $error("no resume");
  a_mask: assert property (p_mask) else $error("unmask write wrong");
  c_kill: cover property (o_kill_insn);
  c_ret: cover property (o_resume_valid);
  c_nest: cover property (o_take_valid && o_active_nesting_bits[12]);
endmodule
bind core_event_stage core_event_stage_asserts chk (.i_clock, .i_rst_n,
  .i_general_event_levels, .i_save_done, .i_return, .i_unmask_we, .i_unmask_wdata,
  .o_event_latch_bits, .o_event_unmask_bits, .o_active_nesting_bits, .o_take_valid,
  .o_take_level, .o_save_req, .o_kill_insn, .o_resume_valid);

// *** dv/core_event_controller_tb_top.sv ***
/*
  testbench: events, nesting, masking, returns.
  assumes design, model and checker compiled first.
*/
`timescale 1ns/100ps
module core_event_controller_tb_top;
  logic i_clock, i_rst_n, i_soft_raise, i_return, i_unmask_we, i_latch_clr_we;
  logic i_save_done, i_emu_exit, o_take_valid, o_resume_valid, o_save_req, o_kill_insn;
  logic o_sys_reset;
  logic [1:0] o_core_mode;
  logic [3:0] i_soft_raise_level, o_take_level, stk [$];
  logic [6:0] periph;
  logic [7:0] ev;
  logic [8:0] lv;
  logic [15:0] i_unmask_wdata, i_latch_clr_bits, o_event_latch_bits, o_event_unmask_bits;
  logic [15:0] o_active_nesting_bits;
  logic [31:0] i_pc, o_resume_addr, lfsr, ret [16];
  int bad_count, n_tests, kills, resets;
  core_event_stage dut (.i_clock, .i_rst_n, .i_emu_req(ev[0]), .i_reset_req(ev[1]),
    .i_nmi_pin(ev[2]), .i_watchdog_nmi(ev[3]), .i_exc_misalign(ev[4]),
    .i_exc_undef(ev[5]), .i_hw_error(ev[6]), .i_core_timer(ev[7]),
    .i_general_event_levels(lv), .i_soft_raise, .i_soft_raise_level, .i_pc, .i_return,
    .i_unmask_we, .i_unmask_wdata, .i_latch_clr_we, .i_latch_clr_bits, .i_save_done,
    .i_emu_exit, .o_event_latch_bits, .o_event_unmask_bits, .o_active_nesting_bits,
    .o_take_valid, .o_take_level, .o_resume_addr, .o_resume_valid, .o_save_req,
    .o_kill_insn, .o_sys_reset, .o_core_mode);
  routing_stage_model far_end (.i_clock, .i_rst_n, .i_periph_req(periph), .o_levels(lv));
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (o_kill_insn === 1'b1) kills++;
    if (o_sys_reset === 1'b1) resets++;
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [3:0] ev_level(input int i);
    logic [3:0] t [8] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h5, 4'h6};
    return t[i];
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic pulse(input int i);
    @(negedge i_clock) ev[i] = 1'b1;
    @(negedge i_clock) ev[i] = 1'b0;
  endtask
  task automatic serve(input logic [3:0] l);
    int k;
    for (k = 0; k < 40 && o_save_req !== 1'b1; k++) @(negedge i_clock);
    @(negedge i_clock) i_save_done = 1'b1;
    @(negedge i_clock) i_save_done = 1'b0;
    for (k = 0; k < 9 && o_take_valid !== 1'b1; k++) #1 @(posedge i_clock) #1;
    check("take_level", o_take_level, l);
    check("nest_bit", o_active_nesting_bits[l], 1);
    ret[l] = i_pc;
    stk.push_back(l);
    @(negedge i_clock) i_pc = rnd();
  endtask
  task automatic ret_chk();
    logic [3:0] l;
    l = stk.pop_back();
    @(negedge i_clock) i_return = 1'b1;
    @(posedge i_clock) #1;
    check("resume_addr", o_resume_addr, ret[l]);
    check("nest_clr", o_active_nesting_bits[l], 0);
    @(negedge i_clock) i_return = 1'b0;
  endtask
  initial begin
    int k, j;
    lfsr = 32'heaf6e9dc;
    {i_rst_n, i_soft_raise, i_return, i_unmask_we, i_latch_clr_we, i_save_done} = 6'h00;
    {i_emu_exit, ev, periph, i_soft_raise_level} = 20'h00000;
    {i_unmask_wdata, i_latch_clr_bits, i_pc} = 64'h0;
    repeat (6) @(negedge i_clock);
    i_rst_n = 1'b1;
    check("unmask_rst", o_event_unmask_bits, 16'h001f);
    check("mode_rst", o_core_mode, 1);
    i_unmask_we = 1'b1;
    i_unmask_wdata = 16'hfbf0;
    @(negedge i_clock) i_unmask_we = 1'b0;
    check("unmask_wr", o_event_unmask_bits, 16'hfbff);
    periph[3] = 1'b1;
    repeat (8) @(negedge i_clock);
    check("masked_latch", o_event_latch_bits, 16'h0400);
    check("masked_nest", o_active_nesting_bits, 16'h0000);
    i_latch_clr_we = 1'b1;
    i_latch_clr_bits = 16'hffff;
    @(negedge i_clock) i_latch_clr_we = 1'b0;
    check("latch_clr", o_event_latch_bits, 16'h0000);
    {periph[3], i_unmask_we, i_unmask_wdata} = {2'h1, 16'hffff};
    @(negedge i_clock) i_unmask_we = 1'b0;
    for (k = 2; k < 8; k++) begin
      pulse(k);
      serve(ev_level(k));
      ret_chk();
    end
    check("kills", kills, 2);
    {i_soft_raise, i_soft_raise_level, ev[6]} = 6'h3f;
    @(negedge i_clock) {i_soft_raise, ev[6]} = 2'h0;
    serve(4'h5);
    ret_chk();
    serve(4'hf);
    ret_chk();
    {i_soft_raise, i_soft_raise_level} = 5'h15;
    @(negedge i_clock) i_soft_raise = 1'b0;
    repeat (3) @(negedge i_clock);
    check("soft_low", o_event_latch_bits, 16'h0000);
    for (k = 0; k < 14; k++) begin
      j = k < 7 ? k : int'(rnd() % 7);
      periph[j] = 1'b1;
      serve(4'h7 + 4'(j));
      periph[j] = 1'b0;
      if (j == 5) pulse(2);
      if (j == 5) serve(4'h2);
      if (j == 5) check("nested", o_active_nesting_bits, 16'h1004);
      if (j == 5) ret_chk();
      ret_chk();
    end
    pulse(0);
    serve(4'h0);
    check("mode_emu", o_core_mode, 2);
    @(negedge i_clock) i_emu_exit = 1'b1;
    @(negedge i_clock) i_emu_exit = 1'b0;
    check("mode_exit", o_core_mode, 1);
    ret_chk();
    pulse(1);
    serve(4'h1);
    repeat (2) @(negedge i_clock);
    check("sys_reset", resets, 1);
    results();
  end
  initial begin
    #400000;
    bad_count++;
    results();
  end
endmodule
